// file: nav_sensor_config_registers.v
/*
 Configuration and status register bank of an optical motion sensor,
 reached over the four-wire serial port (select, clock, data in/out).
 Assumes the motion engine supplies status events, shutter time and
 feature counts, and consumes the decoded settings below.
 First byte: bit 7 set for write, bits 6:0 address; second byte data.
*/
`timescale 1ns/1ns
`include "nav_sensor_consts.vh"

module nav_sensor_config_registers
#(
  // Arbitrary neutral revision identifier
  parameter [7:0] REVISION_ID = 8'h3c
)
(
  // Clock and reset
  input wire sys_clk,
  input wire rst_b,
  // Serial port pins
  input wire sel_b,
  input wire sclk,
  input wire mosi,
  output reg miso,
  output reg miso_oe,
  // Motion engine events
  input wire motion_event,
  input wire dump_valid_in,
  input wire dump_first_in,
  input wire y_overflow_event,
  input wire x_overflow_event,
  input wire status_read_clear,
  // Motion engine measurements
  input wire [15:0] shutter_time,
  input wire [4:0] feature_count,
  input wire [4:0] run_quality_minimum,
  // Decoded settings
  output reg [7:0] shutter_limit,
  output reg shutter_over_limit,
  output reg [4:0] min_feature_count,
  output reg [2:0] min_feature_size,
  output reg rest_allowed,
  output reg wake_ok,
  output reg [2:0] decorrelation_shift,
  output reg resolution_select_enable,
  output reg [12:0] counts_per_inch,
  output reg [15:0] preheat_clocks,
  output reg [17:0] frame_period,
  output reg full_reset_pulse,
  output reg partial_reset_pulse
);

// ----------------------------------------
// Reset release and pin synchronisers
// ----------------------------------------
reg rst_meta_q;
reg rst_sync_q;
wire rst_sync_b;
reg [1:0] sel_sync_q;
reg [1:0] sclk_sync_q;
reg [1:0] mosi_sync_q;
reg sclk_last_q;

assign rst_sync_b = rst_sync_q;

// Reset asserts at once, releases after two clocks
always @(posedge sys_clk or negedge rst_b)
begin
  if (!rst_b)
  begin
    rst_meta_q <= 1'b0;
    rst_sync_q <= 1'b0;
  end
  else
  begin
    rst_meta_q <= 1'b1;
    rst_sync_q <= rst_meta_q;
  end
end

// Two stages on every pin; only stage two is read by logic
always @(posedge sys_clk or negedge rst_sync_b)
begin
  if (!rst_sync_b)
  begin
    sel_sync_q <= 2'b11;
    sclk_sync_q <= 2'b11;
    mosi_sync_q <= 2'b00;
    sclk_last_q <= 1'b1;
  end
  else
  begin
    sel_sync_q <= {sel_sync_q[0], sel_b};
    sclk_sync_q <= {sclk_sync_q[0], sclk};
    mosi_sync_q <= {mosi_sync_q[0], mosi};
    sclk_last_q <= sclk_sync_q[1];
  end
end

wire sel = ~sel_sync_q[1];
wire sclk_rise = sclk_sync_q[1] & ~sclk_last_q;
wire sclk_fall = ~sclk_sync_q[1] & sclk_last_q;

// ----------------------------------------
// Byte shifter
// ----------------------------------------
wire [7:0] rx_byte;
wire rx_done;
wire tx_bit;
reg load_q;
reg [7:0] read_data;

serial_shifter u_shift
(
  .sys_clk(sys_clk),
  .rst_sync_b(rst_sync_b),
  .sel(sel),
  .rise(sclk_rise),
  .fall(sclk_fall),
  .mosi_bit(mosi_sync_q[1]),
  .load(load_q),
  .tx_byte(read_data),
  .rx_byte(rx_byte),
  .rx_done(rx_done),
  .tx_bit(tx_bit)
);

// ----------------------------------------
// Transaction state machine
// ----------------------------------------
localparam [2:0] ST_ADDR = 3'b001;
localparam [2:0] ST_WDATA = 3'b010;
localparam [2:0] ST_RDATA = 3'b100;

reg [2:0] state_q;
reg [6:0] addr_q;
reg wr_stb;

// Address byte picks direction; data byte writes or ends the read
always @(posedge sys_clk or negedge rst_sync_b)
begin
  if (!rst_sync_b)
  begin
    state_q <= ST_ADDR;
    addr_q <= 7'h00;
    wr_stb <= 1'b0;
    load_q <= 1'b0;
  end
  else
  begin
    wr_stb <= 1'b0;
    load_q <= 1'b0;
    if (!sel)
      state_q <= ST_ADDR;
    else if (rx_done)
    begin
      case (state_q)
        ST_ADDR:
        begin
          addr_q <= rx_byte[6:0];
          if (rx_byte[7])
            state_q <= ST_WDATA;
          else
          begin
            state_q <= ST_RDATA;
            load_q <= 1'b1;
          end
        end
        ST_WDATA:
        begin
          wr_stb <= 1'b1;
          state_q <= ST_ADDR;
        end
        ST_RDATA:
          state_q <= ST_ADDR;
        default:
          state_q <= ST_ADDR;
      endcase
    end
  end
end

// Data driven only while a read byte is being returned
always @(posedge sys_clk or negedge rst_sync_b)
begin
  if (!rst_sync_b)
  begin
    miso <= 1'b0;
    miso_oe <= 1'b0;
  end
  else
  begin
    miso <= tx_bit;
    miso_oe <= sel && (state_q == ST_RDATA);
  end
end

// ----------------------------------------
// Writable registers
// ----------------------------------------
reg [7:0] shutter_limit_reg;
reg [7:0] surface_quality_limit_reg;
reg [7:0] navigation_control_two;
reg [7:0] wake_and_decorrelation;
reg [7:0] resolution;
reg [7:0] emitter_preheat;
reg [7:0] frame_gap;
wire [7:0] wdata = rx_byte;

// A full reset command restores every setting; status stays read-only
always @(posedge sys_clk or negedge rst_sync_b)
begin
  if (!rst_sync_b)
  begin
    shutter_limit_reg <= `RST_SHUTTER_LIMIT;
    surface_quality_limit_reg <= `RST_QUALITY_LIMIT;
    navigation_control_two <= `RST_NAV_CTRL_TWO;
    wake_and_decorrelation <= `RST_WAKE_DECORR;
    resolution <= `RST_RESOLUTION;
    emitter_preheat <= `RST_PREHEAT;
    frame_gap <= `RST_FRAME_GAP;
  end
  else if (full_reset_pulse)
  begin
    shutter_limit_reg <= `RST_SHUTTER_LIMIT;
    surface_quality_limit_reg <= `RST_QUALITY_LIMIT;
    navigation_control_two <= `RST_NAV_CTRL_TWO;
    wake_and_decorrelation <= `RST_WAKE_DECORR;
    resolution <= `RST_RESOLUTION;
    emitter_preheat <= `RST_PREHEAT;
    frame_gap <= `RST_FRAME_GAP;
  end
  else if (wr_stb)
  begin
    // Unlisted and read-only offsets fall through untouched
    case (addr_q)
      `ADDR_SHUTTER_LIMIT: shutter_limit_reg <= wdata;
      `ADDR_QUALITY_LIMIT: surface_quality_limit_reg <= wdata;
      // Bits 6:0 are kept zero whatever is written
      `ADDR_NAV_CTRL_TWO: navigation_control_two <= wdata & `MASK_NAV_CTRL_TWO;
      `ADDR_WAKE_DECORR: wake_and_decorrelation <= wdata & `MASK_WAKE_DECORR;
      `ADDR_RESOLUTION: resolution <= wdata & `MASK_RESOLUTION;
      `ADDR_PREHEAT: emitter_preheat <= wdata;
      `ADDR_FRAME_GAP: frame_gap <= wdata;
      default: frame_gap <= frame_gap;
    endcase
  end
end

// Reset command decode into one-cycle pulses
always @(posedge sys_clk or negedge rst_sync_b)
begin
  if (!rst_sync_b)
  begin
    full_reset_pulse <= 1'b0;
    partial_reset_pulse <= 1'b0;
  end
  else
  begin
    full_reset_pulse <= 1'b0;
    partial_reset_pulse <= 1'b0;
    if (wr_stb && addr_q == `ADDR_RESET_CMD)
    begin
      full_reset_pulse <= (wdata == `CMD_FULL_RESET_A) ||
        (wdata == `CMD_FULL_RESET_B);
      partial_reset_pulse <= (wdata == `CMD_PART_RESET_A) ||
        (wdata == `CMD_PART_RESET_B);
    end
  end
end

// ----------------------------------------
// Extended motion status
// ----------------------------------------
reg motion_seen_flag;
reg pixel_dump_valid;
reg pixel_dump_first;
reg y_overflow_q;
reg x_overflow_q;

// Motion and overflow flags sticky, dump flags follow input; a new event beats a read clear in the same cycle
always @(posedge sys_clk or negedge rst_sync_b)
begin
  if (!rst_sync_b)
  begin
    motion_seen_flag <= 1'b0;
    y_overflow_q <= 1'b0;
    x_overflow_q <= 1'b0;
    pixel_dump_valid <= 1'b0;
    pixel_dump_first <= 1'b0;
  end
  else
  begin
    motion_seen_flag <= motion_event | (motion_seen_flag & ~status_read_clear);
    y_overflow_q <= y_overflow_event | (y_overflow_q & ~status_read_clear);
    x_overflow_q <= x_overflow_event | (x_overflow_q & ~status_read_clear);
    pixel_dump_valid <= dump_valid_in;
    pixel_dump_first <= dump_first_in;
  end
end

// Read mux; reserved status bits read zero
always @*
begin
  read_data = `RST_BYTE_ZERO;
  case (addr_q)
    `ADDR_REVISION: read_data = REVISION_ID;
    `ADDR_MOTION_STATUS:
    begin
      read_data[`BIT_MOTION_SEEN] = motion_seen_flag;
      read_data[`BIT_DUMP_VALID] = pixel_dump_valid;
      read_data[`BIT_DUMP_FIRST] = pixel_dump_first;
      read_data[`BIT_Y_OVERFLOW] = y_overflow_q;
      read_data[`BIT_X_OVERFLOW] = x_overflow_q;
    end
    `ADDR_SHUTTER_LIMIT: read_data = shutter_limit_reg;
    `ADDR_QUALITY_LIMIT: read_data = surface_quality_limit_reg;
    `ADDR_NAV_CTRL_TWO: read_data = navigation_control_two;
    `ADDR_WAKE_DECORR: read_data = wake_and_decorrelation;
    `ADDR_RESOLUTION: read_data = resolution;
    `ADDR_PREHEAT: read_data = emitter_preheat;
    `ADDR_FRAME_GAP: read_data = frame_gap;
    `ADDR_REV_COMPLEMENT: read_data = ~REVISION_ID;
    default: read_data = `RST_BYTE_ZERO;
  endcase
end

// ----------------------------------------
// Decoded settings
// ----------------------------------------
wire [7:0] wake_product = {5'h00, wake_and_decorrelation[6:4]} *
  {3'h0, run_quality_minimum};
wire [3:0] cpi_code = resolution[3:0];

// Registered so every output comes from a flip-flop
always @(posedge sys_clk or negedge rst_sync_b)
begin
  if (!rst_sync_b)
  begin
    shutter_limit <= `RST_SHUTTER_LIMIT;
    shutter_over_limit <= 1'b0;
    min_feature_count <= 5'h00;
    min_feature_size <= 3'h0;
    rest_allowed <= 1'b1;
    wake_ok <= 1'b0;
    decorrelation_shift <= 3'h0;
    resolution_select_enable <= 1'b0;
    counts_per_inch <= `DPI_FULL;
    preheat_clocks <= `PREHEAT_OFFSET;
    frame_period <= `FRAME_BASE_CLOCKS;
  end
  else
  begin
    shutter_limit <= shutter_limit_reg;
    // Shutter above limit asks to stay out of rest
    shutter_over_limit <= shutter_time > {8'h00, shutter_limit_reg};
    min_feature_count <= surface_quality_limit_reg[7:3];
    min_feature_size <= surface_quality_limit_reg[2:0];
    rest_allowed <= ~navigation_control_two[`BIT_FORCE_AWAKE];
    wake_ok <= {3'h0, feature_count} >= wake_product;
    decorrelation_shift <= wake_and_decorrelation[2:0];
    resolution_select_enable <= resolution[`BIT_RES_ENABLE];
    // Disabled setting falls back to native full resolution
    if (!resolution[`BIT_RES_ENABLE] || cpi_code == 4'h0 || cpi_code > `DPI_MAX_CODE)
      counts_per_inch <= `DPI_FULL;
    else
      counts_per_inch <= {9'h000, cpi_code} * `DPI_STEP;
    preheat_clocks <= {3'h0, emitter_preheat, 5'h00} + `PREHEAT_OFFSET;
    frame_period <= {2'b00, shutter_time} + `FRAME_BASE_CLOCKS +
      {5'h00, frame_gap, 5'h00};
  end
end

endmodule

// file: nav_sensor_consts.vh
/*
 Constants for the optical motion sensor configuration register bank:
 register offsets, field positions, reset values, reset command codes,
 frame timing counts and serial port framing.
 Assumes it is included by its bare name from the design files.
*/
`ifndef NAV_SENSOR_CONSTS_VH
`define NAV_SENSOR_CONSTS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADDR_REVISION 7'h01
`define ADDR_MOTION_STATUS 7'h1b
`define ADDR_SHUTTER_LIMIT 7'h1c
`define ADDR_QUALITY_LIMIT 7'h1d
`define ADDR_NAV_CTRL_TWO 7'h22
`define ADDR_WAKE_DECORR 7'h25
`define ADDR_RESOLUTION 7'h33
`define ADDR_PREHEAT 7'h34
`define ADDR_FRAME_GAP 7'h35
`define ADDR_RESET_CMD 7'h3a
`define ADDR_REV_COMPLEMENT 7'h3f

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_SHUTTER_LIMIT 8'h41
`define RST_QUALITY_LIMIT 8'h3d
`define RST_NAV_CTRL_TWO 8'h00
`define RST_WAKE_DECORR 8'h61
`define RST_RESOLUTION 8'h04
`define RST_PREHEAT 8'ha0
`define RST_FRAME_GAP 8'h00
`define RST_BYTE_ZERO 8'h00

// ----------------------------------------
// Field positions and write masks
// ----------------------------------------
`define BIT_MOTION_SEEN 7
`define BIT_DUMP_VALID 6
`define BIT_DUMP_FIRST 5
`define BIT_Y_OVERFLOW 4
`define BIT_X_OVERFLOW 3
`define BIT_FORCE_AWAKE 7
`define BIT_RES_ENABLE 4
`define MASK_NAV_CTRL_TWO 8'h80
`define MASK_WAKE_DECORR 8'h77
`define MASK_RESOLUTION 8'h1f

// ----------------------------------------
// Reset command codes
// ----------------------------------------
`define CMD_FULL_RESET_A 8'h5a
`define CMD_FULL_RESET_B 8'h5b
`define CMD_PART_RESET_A 8'h96
`define CMD_PART_RESET_B 8'h97

// ----------------------------------------
// Timing and resolution
// ----------------------------------------
`define PREHEAT_OFFSET 16'd30
`define FRAME_BASE_CLOCKS 18'd3400
`define DPI_STEP 13'd250
`define DPI_MAX_CODE 4'h8
`define DPI_FULL 13'd4000
`define SER_BITS 4'd8

`endif

// file: serial_shifter.v
/*
 Byte shifter for the four-wire serial port: collects eight bits on
 rising link clock edges and presents the byte to send on falling edges.
 Assumes edge pulses come already synchronised to sys_clk.
*/
`timescale 1ns/1ns
`include "nav_sensor_consts.vh"

module serial_shifter
(
  // Clock and reset
  input wire sys_clk,
  input wire rst_sync_b,
  // Frame and edges
  input wire sel,
  input wire rise,
  input wire fall,
  input wire mosi_bit,
  // Byte ports
  input wire load,
  input wire [7:0] tx_byte,
  output reg [7:0] rx_byte,
  output reg rx_done,
  output wire tx_bit
);

reg [7:0] rx_q;
reg [7:0] tx_q;
reg [3:0] cnt_q;

assign tx_bit = tx_q[7];

// Shift in on rising, shift out on falling; count restarts between frames
always @(posedge sys_clk or negedge rst_sync_b)
begin
  if (!rst_sync_b)
  begin
    rx_q <= `RST_BYTE_ZERO;
    tx_q <= `RST_BYTE_ZERO;
    cnt_q <= 4'h0;
    rx_byte <= `RST_BYTE_ZERO;
    rx_done <= 1'b0;
  end
  else
  begin
    rx_done <= 1'b0;
    if (!sel)
      cnt_q <= 4'h0;
    else if (rise)
    begin
      rx_q <= {rx_q[6:0], mosi_bit};
      if (cnt_q == `SER_BITS - 4'd1)
      begin
        cnt_q <= 4'h0;
        rx_byte <= {rx_q[6:0], mosi_bit};
        rx_done <= 1'b1;
      end
      else
        cnt_q <= cnt_q + 4'd1;
    end
    if (load)
      tx_q <= tx_byte;
    else if (sel && fall && cnt_q != 4'h0)
      tx_q <= {tx_q[6:0], 1'b0};
  end
end

endmodule

// file: nav_monitor.sv
/*
 Checker on the register bank ports.
 Assumes the bind at the foot of this file and a single sys_clk domain.
*/
`timescale 1ns/1ns
module nav_monitor
(
  // Clock and reset
  input wire sys_clk,
  input wire rst_b,
  // Watched ports
  input wire sel_b,
  input wire miso_oe,
  input wire [15:0] shutter_time,
  input wire [7:0] shutter_limit,
  input wire shutter_over_limit,
  input wire resolution_select_enable,
  input wire [12:0] counts_per_inch,
  input wire [15:0] preheat_clocks,
  input wire [17:0] frame_period,
  input wire full_reset_pulse,
  input wire partial_reset_pulse
);
  // --------------
  // Port relations
  // --------------
  // Inputs held four edges first, so the registered outputs have caught up
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  preheat_a: assert property (preheat_clocks[4:0] == 5'd30)
    else $error("preheat tail wrong");
  frame_a: assert property ($stable(shutter_time) [*4] |->
    ((frame_period - shutter_time - 18'd3400) & 18'h1f) == 0 &&
    frame_period >= 18'd3400 + shutter_time)
    else $error("frame period wrong");
  over_a: assert property (($stable(shutter_time) && $stable(shutter_limit)) [*4] |->
    shutter_over_limit == (shutter_time > shutter_limit))
    else $error("shutter compare wrong");
  dpi_set_a: assert property (counts_per_inch == 13'd4000 ||
    (counts_per_inch % 250 == 0 && counts_per_inch != 0 && counts_per_inch <= 2000))
    else $error("resolution value wrong");
  dpi_off_a: assert property (!resolution_select_enable |-> counts_per_inch == 13'd4000)
    else $error("resolution not disabled");
  pulse_len_a: assert property (full_reset_pulse || partial_reset_pulse |=>
    !full_reset_pulse && !partial_reset_pulse)
    else $error("reset pulse too long");
  pulse_excl_a: assert property (!(full_reset_pulse && partial_reset_pulse))
    else $error("both reset pulses");
  full_restore_a: assert property (full_reset_pulse |-> ##[0:3]
    (shutter_limit == 8'h41 && preheat_clocks == 16'd5150))
    else $error("full reset did not restore");
  idle_out_a: assert property (sel_b [*4] |-> !miso_oe)
    else $error("data out driven while idle");
  settings_stand_a: assert property (sel_b [*8] |=>
    $stable(shutter_limit) && $stable(counts_per_inch) && $stable(preheat_clocks))
    else $error("setting changed while idle");
endmodule

bind nav_sensor_config_registers nav_monitor mon (.sys_clk(sys_clk), .rst_b(rst_b),
  .sel_b(sel_b), .miso_oe(miso_oe), .shutter_time(shutter_time),
  .shutter_limit(shutter_limit), .shutter_over_limit(shutter_over_limit),
  .resolution_select_enable(resolution_select_enable),
  .counts_per_inch(counts_per_inch), .preheat_clocks(preheat_clocks),
  .frame_period(frame_period), .full_reset_pulse(full_reset_pulse),
  .partial_reset_pulse(partial_reset_pulse));

// file: serial_host.sv
/*
 Model of the external controller on the four-wire serial port.
 Assumes the bench calls xfer; link clock period is 400 ns.
*/
`timescale 1ns/1ns
module serial_host
(
  // Serial pins
  output reg sel_b,
  output reg sclk,
  output reg mosi,
  input wire miso,
  input wire miso_oe
);
  integer i;
  // Idle: deselected, clock parked high
  initial
  begin
    sel_b = 1'b1;
    sclk = 1'b1;
    mosi = 1'b0;
  end
  // One address and data pair per select, MSB first
  // Low phase is the longer one so shifted read bits settle before the rise
  task xfer(input [7:0] a, input [7:0] d, output [7:0] r);
    reg [15:0] w;
    begin
      w = {a, d};
      r = 8'h00;
      sel_b = 1'b0;
      #300;
      for (i = 15; i >= 0; i = i - 1)
      begin
        sclk = 1'b0;
        mosi = w[i];
        #250;
        sclk = 1'b1;
        if (i < 8)
          r[i] = miso_oe ? miso : 1'bx;
        #150;
      end
      #400;
      sel_b = 1'b1;
      mosi = ~mosi; // Released line shows no stale value
      #400;
    end
  endtask
endmodule

// file: testbench.sv
/*
 Self-checking bench for the sensor register bank.
 Assumes serial_host drives the port and nav_monitor is bound.
*/
`timescale 1ns/1ns
module testbench;
  localparam [7:0] REV = 8'h5e; // Arbitrary revision identifier
  reg sys_clk, rst_b, motion_event, dump_valid_in, dump_first_in;
  reg y_overflow_event, x_overflow_event, status_read_clear;
  reg [15:0] shutter_time;
  reg [4:0] feature_count, run_quality_minimum;
  reg [7:0] r, c;
  reg seen_full, seen_part;
  wire sel_b, sclk, mosi, miso, miso_oe, shutter_over_limit, rest_allowed, wake_ok;
  wire resolution_select_enable, full_reset_pulse, partial_reset_pulse;
  wire [7:0] shutter_limit;
  wire [4:0] min_feature_count;
  wire [2:0] min_feature_size, decorrelation_shift;
  wire [12:0] counts_per_inch;
  wire [15:0] preheat_clocks;
  wire [17:0] frame_period;
  integer num_errors, compares, k;
  serial_host host (.sel_b(sel_b), .sclk(sclk), .mosi(mosi), .miso(miso), .miso_oe(miso_oe));
  nav_sensor_config_registers #(.REVISION_ID(REV)) uut (.sys_clk(sys_clk), .rst_b(rst_b),
    .sel_b(sel_b), .sclk(sclk), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
    .motion_event(motion_event), .dump_valid_in(dump_valid_in),
    .dump_first_in(dump_first_in), .y_overflow_event(y_overflow_event),
    .x_overflow_event(x_overflow_event), .status_read_clear(status_read_clear),
    .shutter_time(shutter_time), .feature_count(feature_count),
    .run_quality_minimum(run_quality_minimum), .shutter_limit(shutter_limit),
    .shutter_over_limit(shutter_over_limit), .min_feature_count(min_feature_count),
    .min_feature_size(min_feature_size), .rest_allowed(rest_allowed), .wake_ok(wake_ok),
    .decorrelation_shift(decorrelation_shift),
    .resolution_select_enable(resolution_select_enable),
    .counts_per_inch(counts_per_inch), .preheat_clocks(preheat_clocks),
    .frame_period(frame_period), .full_reset_pulse(full_reset_pulse),
    .partial_reset_pulse(partial_reset_pulse));
  // ------------
  // Helper tasks
  // ------------
  task check(input [17:0] got, input [17:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp)
      begin
        num_errors = num_errors + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wr(input [6:0] a, input [7:0] d);
    begin
      host.xfer({1'b1, a}, d, r);
    end
  endtask
  task rd(input [6:0] a, input [7:0] e);
    begin
      host.xfer({1'b0, a}, 8'h00, r);
      check(r, e);
    end
  endtask
  // Drive points sit a fixed 5 ns after the rising edge
  task cyc(input integer n);
    begin
      repeat (n) @(posedge sys_clk);
      #5;
    end
  endtask
  task final_report;
    begin
      if (num_errors == 0 && compares > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  // Clock and watchdog
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial
  begin
    #1000000;
    num_errors = num_errors + 1;
    final_report;
  end
  // One-cycle pulses are caught here and cleared by the sequence
  always @(posedge sys_clk)
  begin
    if (full_reset_pulse === 1'b1)
      seen_full <= 1'b1;
    if (partial_reset_pulse === 1'b1)
      seen_part <= 1'b1;
  end
  // -------------
  // Test sequence
  // -------------
  initial
  begin
    {num_errors, compares, seen_full, seen_part} = 0;
    {rst_b, motion_event, dump_valid_in, dump_first_in} = 4'h0;
    {y_overflow_event, x_overflow_event, status_read_clear} = 3'h0;
    shutter_time = 16'h0020;
    feature_count = 5'd0;
    run_quality_minimum = 5'd2;
    cyc(3);
    rst_b = 1'b1;
    cyc(6);
    check(preheat_clocks, 18'd5150);
    check(counts_per_inch, 18'd4000);
    check(frame_period, 18'd3432);
    rd(7'h1c, 8'h41);
    rd(7'h1d, 8'h3d);
    rd(7'h22, 8'h00);
    rd(7'h25, 8'h61);
    rd(7'h33, 8'h04);
    rd(7'h34, 8'ha0);
    rd(7'h35, 8'h00);
    rd(7'h50, 8'h00);
    wr(7'h3f, 8'h00);
    wr(7'h01, 8'h00);
    wr(7'h1b, 8'hff);
    rd(7'h3f, ~REV);
    rd(7'h01, REV);
    rd(7'h1b, 8'h00);
    wr(7'h1c, 8'h1f);
    rd(7'h1c, 8'h1f);
    check(shutter_limit, 18'h1f);
    check(shutter_over_limit, 18'd1);
    shutter_time = 16'h001f;
    cyc(4);
    check(shutter_over_limit, 18'd0);
    wr(7'h1d, 8'hab);
    check({min_feature_count, min_feature_size}, 18'hab);
    wr(7'h22, 8'h9f);
    rd(7'h22, 8'h80);
    check(rest_allowed, 18'd0);
    // Write to unlisted offset 0f between a rest-disable write and a rest-enable write
    wr(7'h22, 8'h80);
    wr(7'h0f, 8'h10);
    wr(7'h22, 8'h00);
    check(rest_allowed, 18'd1);
    feature_count = 5'd12;
    cyc(3);
    check(wake_ok, 18'd1);
    feature_count = 5'd11;
    cyc(3);
    check(wake_ok, 18'd0);
    wr(7'h25, 8'hff);
    rd(7'h25, 8'h77);
    check(decorrelation_shift, 18'd7);
    feature_count = 5'd14;
    cyc(3);
    check(wake_ok, 18'd1);
    for (k = 0; k < 9; k = k + 1)
    begin
      wr(7'h33, 8'h10 | k[7:0]);
      check(counts_per_inch, k == 0 ? 18'd4000 : 18'd250 * k[17:0]);
      check(resolution_select_enable, 18'd1);
    end
    wr(7'h33, 8'h02);
    check(counts_per_inch, 18'd4000);
    wr(7'h33, 8'hff);
    rd(7'h33, 8'h1f);
    wr(7'h34, 8'h01);
    check(preheat_clocks, 18'd62);
    wr(7'h35, 8'h02);
    check(frame_period, 18'd3495);
    shutter_time = 16'h0100;
    cyc(4);
    check(frame_period, 18'd3720);
    {motion_event, x_overflow_event, dump_valid_in} = 3'h7;
    cyc(1);
    {motion_event, x_overflow_event} = 2'h0;
    cyc(2);
    rd(7'h1b, 8'hc8);
    {dump_valid_in, dump_first_in, y_overflow_event} = 3'h3;
    cyc(1);
    y_overflow_event = 1'b0;
    cyc(2);
    rd(7'h1b, 8'hb8);
    status_read_clear = 1'b1;
    cyc(1);
    status_read_clear = 1'b0;
    cyc(2);
    rd(7'h1b, 8'h20);
    // Event and clear in one cycle: the event must win
    {motion_event, status_read_clear} = 2'b11;
    cyc(1);
    {motion_event, status_read_clear} = 2'b00;
    cyc(2);
    rd(7'h1b, 8'ha0);
    // Both codes of each reset kind, then a near miss
    for (k = 0; k < 5; k = k + 1)
    begin
      c = (k < 2) ? 8'h5a + k[7:0] : (k < 4) ? 8'h94 + k[7:0] : 8'h5c;
      wr(7'h1c, 8'h77);
      {seen_full, seen_part} = 2'b00;
      wr(7'h3a, c);
      check(seen_full, k < 2);
      check(seen_part, k == 2 || k == 3);
      rd(7'h1c, k < 2 ? 8'h41 : 8'h77);
    end
    check(preheat_clocks, 18'd5150);
    final_report;
  end
endmodule
